// [verilog/bcdp_defs.vh]
// Register map, field layout, reset values and timing constants of the bus clock and PLL block.
`ifndef BCDP_DEFS_VH
`define BCDP_DEFS_VH
`define BCDP_ADDR_W 8
`define BCDP_DATA_W 32
`define BCDP_OFS_SCM_CTRL 8'h00
`define BCDP_OFS_SCM_STAT 8'h04
`define BCDP_OFS_BASE_PSC 8'h08
`define BCDP_OFS_PB0_PSC 8'h0c
`define BCDP_OFS_PB1_PSC 8'h10
`define BCDP_OFS_PB2_PSC 8'h14
`define BCDP_OFS_TRC_PSC 8'h18
`define BCDP_OFS_PLL_WAIT 8'h1c
`define BCDP_OFS_PLL_CONTROL_FIRST 8'h20
`define BCDP_OFS_PLL_CONTROL_SECOND 8'h24
// Control register fields.
`define BCDP_SEL_HI 7
`define BCDP_SEL_LO 5
`define BCDP_PLL_OSCILLATION_ENABLE_BIT 4
// Status register fields.
`define BCDP_STABLE_BIT 0
// Wait setup fields: wait code and PLL input select.
`define BCDP_WAIT_HI 3
`define BCDP_WAIT_LO 0
`define BCDP_PINC_BIT 4
// PLL control fields: input divider and output divider in the first, multiplier in the second.
`define BCDP_K_HI 7
`define BCDP_K_LO 4
`define BCDP_M_HI 3
`define BCDP_M_LO 0
`define BCDP_N_HI 5
`define BCDP_N_LO 0
// Master clock select codes.
`define BCDP_SEL_FRC 3'h0
`define BCDP_SEL_MAIN 3'h1
`define BCDP_SEL_PLL 3'h2
// Reset values.
`define BCDP_RST_PSC 4'h0
`define BCDP_RST_SEL 3'h0
`define BCDP_RST_WAIT 4'h0
`define BCDP_RST_K 4'h0
`define BCDP_RST_M 4'h0
`define BCDP_RST_N 6'h00
// The PLL wait lasts (code + 1) shifted left by this many fast RC ticks.
`define BCDP_WAIT_SHIFT 8
`define BCDP_WAIT_W 13
`define BCDP_PER_W 16
`endif

// [verilog/bcdp_divider.v]
// Programmable tick divider: passes one tick out of every ratio plus one ticks in.
`timescale 1ns/1ps
`default_nettype none
module bcdp_divider (
   input wire ref_clk_i,
   input wire rst_n_i,
   input wire tick_i,
   input wire [3:0] ratio_i,
   output reg tick_o
);
   reg [3:0] count_r;

   always @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         count_r <= 4'h0;
         tick_o <= 1'b0;
      end else begin
         tick_o <= 1'b0;
         if (tick_i) begin
            // A ratio lowered below the running count ends the period at once.
            if (count_r >= ratio_i) begin
               count_r <= 4'h0;
               tick_o <= 1'b1;
            end else begin
               count_r <= count_r + 4'h1;
            end
         end
      end
   end
endmodule // bcdp_divider
`default_nettype wire

// [verilog/bcdp_clock_ctrl.v]
// Bus clock prescalers and main PLL control, with clocks modelled as one-cycle enable ticks.
`timescale 1ns/1ps
`default_nettype none
`include "bcdp_defs.vh"
module bcdp_clock_ctrl (
   input wire ref_clk_i,
   input wire rst_n_i,
   input wire sw_rst_i,
   input wire main_osc_clk_i,
   input wire fast_rc_clk_i,
   input wire [`BCDP_ADDR_W-1:0] addr_i,
   input wire [`BCDP_DATA_W-1:0] wr_data_i,
   input wire wr_en_i,
   input wire rd_en_i,
   output reg [`BCDP_DATA_W-1:0] rd_data_o,
   output reg master_clk_en_o,
   output wire base_clk_en_o,
   output wire periph_bus0_en_o,
   output wire periph_bus1_en_o,
   output wire periph_bus2_en_o,
   output wire trace_clk_en_o,
   output wire divided_pll_input_o,
   output reg pll_oscillator_output_o,
   output wire main_pll_clock_o,
   output reg pll_stable_o
);
   // Soft state clears on both resets; prescalers only on the full reset.
   wire ctl_rst_n = rst_n_i & ~sw_rst_i;

   reg [2:0] main_sync_r;
   reg [2:0] frc_sync_r;
   reg [3:0] base_psc_r;
   reg [3:0] slv_psc_r [0:3];
   reg [2:0] req_sel_r;
   reg [2:0] act_sel_r;
   reg pll_en_r;
   reg [3:0] wait_code_r;
   reg pll_src_r;
   reg [3:0] k_r;
   reg [3:0] m_r;
   reg [5:0] n_r;
   reg [`BCDP_WAIT_W-1:0] wait_cnt_r;
   reg [`BCDP_PER_W-1:0] per_cnt_r;
   reg [`BCDP_PER_W-1:0] period_r;
   reg [`BCDP_PER_W-1:0] acc_r;
   reg [`BCDP_DATA_W-1:0] rd_nxt;
   wire [3:0] slv_tick;

   // Only the second and third flops feed the edge detect; the first is metastability guard.
   wire main_tick = main_sync_r[1] & ~main_sync_r[2];
   wire frc_tick = frc_sync_r[1] & ~frc_sync_r[2];

   function sel_hit;
      input [`BCDP_ADDR_W-1:0] a;
      input [`BCDP_ADDR_W-1:0] ofs;
      begin
         sel_hit = (a == ofs);
      end
   endfunction

   always @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         main_sync_r <= 3'h0;
         frc_sync_r <= 3'h0;
      end else begin
         main_sync_r <= {main_sync_r[1:0], main_osc_clk_i};
         frc_sync_r <= {frc_sync_r[1:0], fast_rc_clk_i};
      end
   end

   // Prescaler registers survive a software reset.
   integer i;
   always @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         base_psc_r <= `BCDP_RST_PSC;
         for (i = 0; i < 4; i = i + 1) begin
            slv_psc_r[i] <= `BCDP_RST_PSC;
         end
      end else if (wr_en_i) begin
         // No sw_rst_i term here, so the ratios are kept.
         if (sel_hit(addr_i, `BCDP_OFS_BASE_PSC)) begin
            base_psc_r <= wr_data_i[3:0];
         end
         if (sel_hit(addr_i, `BCDP_OFS_PB0_PSC)) begin
            slv_psc_r[0] <= {1'b0, wr_data_i[2:0]};
         end
         if (sel_hit(addr_i, `BCDP_OFS_PB1_PSC)) begin
            slv_psc_r[1] <= {1'b0, wr_data_i[2:0]};
         end
         if (sel_hit(addr_i, `BCDP_OFS_PB2_PSC)) begin
            slv_psc_r[2] <= {1'b0, wr_data_i[2:0]};
         end
         if (sel_hit(addr_i, `BCDP_OFS_TRC_PSC)) begin
            slv_psc_r[3] <= {1'b0, wr_data_i[2:0]};
         end
      end
   end

   // Mode control, PLL setup and PLL control registers.
   always @(posedge ref_clk_i) begin
      if (!ctl_rst_n) begin
         req_sel_r <= `BCDP_RST_SEL;
         pll_en_r <= 1'b0;
         wait_code_r <= `BCDP_RST_WAIT;
         pll_src_r <= 1'b0;
         k_r <= `BCDP_RST_K;
         m_r <= `BCDP_RST_M;
         n_r <= `BCDP_RST_N;
      end else if (wr_en_i) begin
         if (sel_hit(addr_i, `BCDP_OFS_SCM_CTRL)) begin
            req_sel_r <= wr_data_i[`BCDP_SEL_HI:`BCDP_SEL_LO];
            pll_en_r <= wr_data_i[`BCDP_PLL_OSCILLATION_ENABLE_BIT];
         end
         if (sel_hit(addr_i, `BCDP_OFS_PLL_WAIT)) begin
            wait_code_r <= wr_data_i[`BCDP_WAIT_HI:`BCDP_WAIT_LO];
            pll_src_r <= wr_data_i[`BCDP_PINC_BIT];
         end
         if (sel_hit(addr_i, `BCDP_OFS_PLL_CONTROL_FIRST)) begin
            k_r <= wr_data_i[`BCDP_K_HI:`BCDP_K_LO];
            m_r <= wr_data_i[`BCDP_M_HI:`BCDP_M_LO];
         end
         if (sel_hit(addr_i, `BCDP_OFS_PLL_CONTROL_SECOND)) begin
            n_r <= wr_data_i[`BCDP_N_HI:`BCDP_N_LO];
         end
      end
   end

   // Stabilization wait, counted on fast RC ticks only; the PLL lock itself is never seen.
   wire [`BCDP_WAIT_W-1:0] wait_target =
      {({1'b0, wait_code_r} + 5'h01), {`BCDP_WAIT_SHIFT{1'b0}}};
   always @(posedge ref_clk_i) begin
      if (!ctl_rst_n || !pll_en_r) begin
         wait_cnt_r <= {`BCDP_WAIT_W{1'b0}};
         pll_stable_o <= 1'b0;
      end else if (!pll_stable_o && frc_tick) begin
         if (wait_cnt_r + 13'h0001 >= wait_target) begin
            pll_stable_o <= 1'b1;
         end
         wait_cnt_r <= wait_cnt_r + 13'h0001;
      end
   end

   // Input divider K on the selected source, gated by the oscillation enable.
   wire pll_src_tick = pll_src_r ? frc_tick : main_tick;
   bcdp_divider u_k_div (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(ctl_rst_n),
      .tick_i(pll_src_tick & pll_en_r),
      .ratio_i(k_r),
      .tick_o(divided_pll_input_o)
   );

   // The multiplier measures the divided input period in reference cycles and spreads
   // (M+1)*(N+1) ticks over each period with an accumulator. It cannot exceed one tick per
   // reference cycle, so output rates near the reference rate saturate.
   wire [4:0] m_val = {1'b0, m_r} + 5'h01;
   wire [6:0] n_val = {1'b0, n_r} + 7'h01;
   wire [11:0] step = {7'h00, m_val} * {5'h00, n_val};
   wire [`BCDP_PER_W:0] acc_sum = {1'b0, acc_r} + {5'h00, step};
   wire acc_wrap = acc_sum >= {1'b0, period_r};

   always @(posedge ref_clk_i) begin
      if (!ctl_rst_n || !pll_en_r) begin
         per_cnt_r <= {`BCDP_PER_W{1'b0}};
         period_r <= {`BCDP_PER_W{1'b0}};
         acc_r <= {`BCDP_PER_W{1'b0}};
         pll_oscillator_output_o <= 1'b0;
      end else begin
         if (divided_pll_input_o) begin
            per_cnt_r <= {`BCDP_PER_W{1'b0}};
            period_r <= per_cnt_r + 16'h0001;
         end else if (per_cnt_r != {`BCDP_PER_W{1'b1}}) begin
            per_cnt_r <= per_cnt_r + 16'h0001;
         end
         pll_oscillator_output_o <= 1'b0;
         if (period_r != {`BCDP_PER_W{1'b0}}) begin
            if (acc_wrap) begin
               pll_oscillator_output_o <= 1'b1;
               acc_r <= acc_sum[`BCDP_PER_W-1:0] - period_r;
            end else begin
               acc_r <= acc_sum[`BCDP_PER_W-1:0];
            end
         end
      end
   end

   bcdp_divider u_m_div (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(ctl_rst_n),
      .tick_i(pll_oscillator_output_o),
      .ratio_i(m_r),
      .tick_o(main_pll_clock_o)
   );

   // Master clock switch. The PLL code takes effect only once the PLL is stable, and
   // losing stability falls back to the fast RC clock so the bus clocks keep running.
   always @(posedge ref_clk_i) begin
      if (!ctl_rst_n) begin
         act_sel_r <= `BCDP_RST_SEL;
      end else if (act_sel_r == `BCDP_SEL_PLL && !pll_stable_o) begin
         act_sel_r <= `BCDP_SEL_FRC;
      end else if (req_sel_r == `BCDP_SEL_PLL) begin
         if (pll_stable_o) begin
            act_sel_r <= `BCDP_SEL_PLL;
         end
      end else if (req_sel_r == `BCDP_SEL_FRC || req_sel_r == `BCDP_SEL_MAIN) begin
         act_sel_r <= req_sel_r;
      end
   end

   always @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         master_clk_en_o <= 1'b0;
      end else begin
         case (act_sel_r)
            `BCDP_SEL_MAIN: master_clk_en_o <= main_tick;
            `BCDP_SEL_PLL: master_clk_en_o <= main_pll_clock_o;
            default: master_clk_en_o <= frc_tick;
         endcase
      end
   end

   // Prescalers follow the new ratio from the next tick; the block does not guard against
   // a fast master clock with slow ratios unprogrammed, which software must avoid.
   bcdp_divider u_base_div (
      .ref_clk_i(ref_clk_i),
      .rst_n_i(rst_n_i),
      .tick_i(master_clk_en_o),
      .ratio_i(base_psc_r),
      .tick_o(base_clk_en_o)
   );

   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_slv
         bcdp_divider u_div (
            .ref_clk_i(ref_clk_i),
            .rst_n_i(rst_n_i),
            .tick_i(base_clk_en_o),
            .ratio_i(slv_psc_r[g]),
            .tick_o(slv_tick[g])
         );
      end
   endgenerate

   assign periph_bus0_en_o = slv_tick[0];
   assign periph_bus1_en_o = slv_tick[1];
   assign periph_bus2_en_o = slv_tick[2];
   assign trace_clk_en_o = slv_tick[3];

   // Read data; unmapped addresses and idle cycles read as zero.
   always @* begin
      rd_nxt = {`BCDP_DATA_W{1'b0}};
      if (sel_hit(addr_i, `BCDP_OFS_SCM_CTRL)) begin
         rd_nxt[`BCDP_SEL_HI:`BCDP_SEL_LO] = req_sel_r;
         rd_nxt[`BCDP_PLL_OSCILLATION_ENABLE_BIT] = pll_en_r;
      end
      if (sel_hit(addr_i, `BCDP_OFS_SCM_STAT)) begin
         rd_nxt[`BCDP_SEL_HI:`BCDP_SEL_LO] = act_sel_r;
         rd_nxt[`BCDP_STABLE_BIT] = pll_stable_o;
      end
      if (sel_hit(addr_i, `BCDP_OFS_BASE_PSC)) begin
         rd_nxt[3:0] = base_psc_r;
      end
      if (sel_hit(addr_i, `BCDP_OFS_PB0_PSC)) begin
         rd_nxt[2:0] = slv_psc_r[0][2:0];
      end
      if (sel_hit(addr_i, `BCDP_OFS_PB1_PSC)) begin
         rd_nxt[2:0] = slv_psc_r[1][2:0];
      end
      if (sel_hit(addr_i, `BCDP_OFS_PB2_PSC)) begin
         rd_nxt[2:0] = slv_psc_r[2][2:0];
      end
      if (sel_hit(addr_i, `BCDP_OFS_TRC_PSC)) begin
         rd_nxt[2:0] = slv_psc_r[3][2:0];
      end
      if (sel_hit(addr_i, `BCDP_OFS_PLL_WAIT)) begin
         rd_nxt[`BCDP_WAIT_HI:`BCDP_WAIT_LO] = wait_code_r;
         rd_nxt[`BCDP_PINC_BIT] = pll_src_r;
      end
      if (sel_hit(addr_i, `BCDP_OFS_PLL_CONTROL_FIRST)) begin
         rd_nxt[`BCDP_K_HI:`BCDP_K_LO] = k_r;
         rd_nxt[`BCDP_M_HI:`BCDP_M_LO] = m_r;
      end
      if (sel_hit(addr_i, `BCDP_OFS_PLL_CONTROL_SECOND)) begin
         rd_nxt[`BCDP_N_HI:`BCDP_N_LO] = n_r;
      end
   end

   always @(posedge ref_clk_i) begin
      if (!rst_n_i) begin
         rd_data_o <= {`BCDP_DATA_W{1'b0}};
      end else if (rd_en_i) begin
         rd_data_o <= rd_nxt;
      end else begin
         rd_data_o <= {`BCDP_DATA_W{1'b0}};
      end
   end
endmodule // bcdp_clock_ctrl
`default_nettype wire

// [tb/bcdp_clock_monitor.sv]
// Port-level assertions for the bus clock prescaler and PLL control block.
`timescale 1ns/1ps
`default_nettype none
`include "bcdp_defs.vh"
module bcdp_clock_monitor (
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   input wire logic sw_rst_i,
   input wire logic [`BCDP_ADDR_W-1:0] addr_i,
   input wire logic [`BCDP_DATA_W-1:0] wr_data_i,
   input wire logic wr_en_i,
   input wire logic rd_en_i,
   input wire logic [`BCDP_DATA_W-1:0] rd_data_o,
   input wire logic master_clk_en_o,
   input wire logic base_clk_en_o,
   input wire logic periph_bus0_en_o,
   input wire logic trace_clk_en_o,
   input wire logic divided_pll_input_o,
   input wire logic pll_oscillator_output_o,
   input wire logic main_pll_clock_o,
   input wire logic pll_stable_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   chk_rd_idle: assert property (!rd_en_i |=> rd_data_o == '0)
      else $error("read data not zero outside a read slot");
   chk_stat_read: assert property (rd_en_i && addr_i == `BCDP_OFS_SCM_STAT
      |=> rd_data_o[`BCDP_STABLE_BIT] == $past(pll_stable_o))
      else $error("status read does not show the stable flag");
   chk_pll_off: assert property (wr_en_i && addr_i == `BCDP_OFS_SCM_CTRL
      && !wr_data_i[`BCDP_PLL_OSCILLATION_ENABLE_BIT] |=> ##1 !pll_stable_o ##4
      (!divided_pll_input_o && !main_pll_clock_o)[*6])
      else $error("PLL still active after its enable was cleared");
   chk_base_src: assert property (base_clk_en_o |-> $past(master_clk_en_o))
      else $error("base tick without a master tick before it");
   chk_pb0_src: assert property (periph_bus0_en_o |-> $past(base_clk_en_o))
      else $error("peripheral tick without a base tick before it");
   chk_trace_src: assert property (trace_clk_en_o |-> $past(base_clk_en_o))
      else $error("trace tick without a base tick before it");
   chk_pll_src: assert property (main_pll_clock_o |-> $past(pll_oscillator_output_o))
      else $error("PLL clock tick without an oscillator tick before it");
   chk_divin_gap: assert property (divided_pll_input_o |=> !divided_pll_input_o)
      else $error("divided input ticks on two cycles in a row");
   chk_swrst_clear: assert property (sw_rst_i |=> !pll_stable_o && !main_pll_clock_o)
      else $error("PLL state survives a software reset");
endmodule // bcdp_clock_monitor

bind bcdp_clock_ctrl bcdp_clock_monitor u_bcdp_clock_monitor (.ref_clk_i(ref_clk_i),
   .rst_n_i(rst_n_i), .sw_rst_i(sw_rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
   .wr_en_i(wr_en_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o),
   .master_clk_en_o(master_clk_en_o), .base_clk_en_o(base_clk_en_o),
   .periph_bus0_en_o(periph_bus0_en_o), .trace_clk_en_o(trace_clk_en_o),
   .divided_pll_input_o(divided_pll_input_o), .pll_oscillator_output_o(pll_oscillator_output_o),
   .main_pll_clock_o(main_pll_clock_o), .pll_stable_o(pll_stable_o));
`default_nettype wire

// [tb/test_bus_clock_div_pll_control.sv]
// Self-checking bench for the bus clock prescalers and PLL control block.
`timescale 1ns/1ps
`default_nettype none
`include "bcdp_defs.vh"
module test_bus_clock_div_pll_control;
   logic ref_clk_i, rst_n_i, sw_rst_i, main_osc_clk_i, fast_rc_clk_i, wr_en_i, rd_en_i, cnt_on;
   logic [`BCDP_ADDR_W-1:0] addr_i;
   logic [`BCDP_DATA_W-1:0] wr_data_i;
   wire [`BCDP_DATA_W-1:0] rd_data_o;
   wire [8:0] ev;
   wire stable;
   int cn[9];
   int err_total = 0, checked = 0, cyc = 0, t0;
   logic [7:0] pofs[5] = '{8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
   int pv[5] = '{3, 7, 1, 2, 5};
   bcdp_clock_ctrl u_bcdp_clock_ctrl (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
      .sw_rst_i(sw_rst_i), .main_osc_clk_i(main_osc_clk_i), .fast_rc_clk_i(fast_rc_clk_i),
      .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
      .rd_data_o(rd_data_o), .master_clk_en_o(ev[0]), .base_clk_en_o(ev[1]),
      .periph_bus0_en_o(ev[2]), .periph_bus1_en_o(ev[3]), .periph_bus2_en_o(ev[4]),
      .trace_clk_en_o(ev[5]), .divided_pll_input_o(ev[6]), .pll_oscillator_output_o(ev[7]),
      .main_pll_clock_o(ev[8]), .pll_stable_o(stable));
   initial begin
      ref_clk_i = 1'b0;
      forever #5 ref_clk_i = ~ref_clk_i;
   end
   // Source pins toggle slowly so each level lasts well over two reference cycles.
   always @(posedge ref_clk_i) begin
      cyc <= cyc + 1;
      if (cyc % 4 == 3) fast_rc_clk_i <= ~fast_rc_clk_i;
      if (cyc % 12 == 11) main_osc_clk_i <= ~main_osc_clk_i;
      if (cnt_on) for (int i = 0; i < 9; i++) cn[i] <= cn[i] + ev[i];
      // The tick counters are int, so an unknown tick would otherwise clear the whole count to zero unnoticed.
      if (cnt_on && $isunknown(ev)) begin
         err_total++;
         $display("unexpected at %0t: got %h exp %h", $time, ev, 9'h000);
      end
      if (cyc == 40000) begin
         err_total++;
         results;
      end
   end
   task automatic results;
      $display("comparisons %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic near(input int got, input int exp, input int tol);
      checked++;
      if (got < exp - tol || got > exp + tol) begin
         err_total++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      addr_i <= a;
      wr_data_i <= d;
      wr_en_i <= 1'b1;
      @(posedge ref_clk_i);
      wr_en_i <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge ref_clk_i);
      addr_i <= a;
      rd_en_i <= 1'b1;
      @(posedge ref_clk_i);
      rd_en_i <= 1'b0;
      #1 chk(rd_data_o, exp);
   endtask
   // Counts every tick output over n cycles; counters are only cleared while counting is off.
   task automatic window(input int n);
      foreach (cn[i]) cn[i] = 0;
      @(posedge ref_clk_i);
      cnt_on <= 1'b1;
      repeat (n) @(posedge ref_clk_i);
      cnt_on <= 1'b0;
      @(posedge ref_clk_i);
   endtask
   task automatic do_reset;
      rst_n_i <= 1'b0;
      repeat (8) @(posedge ref_clk_i);
      rst_n_i <= 1'b1;
   endtask
   task automatic zero_regs;
      for (int a = 0; a <= 8'h28; a += 4) rd(a[7:0], 32'h0);
   endtask
   initial begin
      {rst_n_i, sw_rst_i, wr_en_i, rd_en_i, cnt_on} = 5'h00;
      {fast_rc_clk_i, main_osc_clk_i, addr_i, wr_data_i} = '0;
      do_reset;
      zero_regs;
      $display("reset value test done");
      for (int i = 0; i < 5; i++) wr(pofs[i], pv[i]);
      for (int i = 0; i < 5; i++) rd(pofs[i], pv[i]);
      wr(8'h30, 32'hff);
      rd(8'h30, 32'h0);
      window(1600);
      near(cn[0], 200, 2);
      near(cn[1], cn[0] / 4, 1);
      for (int i = 1; i < 5; i++) near(cn[i + 1], cn[1] / (pv[i] + 1), 1);
      @(posedge ref_clk_i);
      sw_rst_i <= 1'b1;
      @(posedge ref_clk_i);
      sw_rst_i <= 1'b0;
      for (int i = 0; i < 5; i++) rd(pofs[i], pv[i]);
      $display("prescaler test done");
      wr(`BCDP_OFS_PLL_WAIT, 32'h10);
      wr(`BCDP_OFS_PLL_CONTROL_FIRST, 32'h11);
      wr(`BCDP_OFS_PLL_CONTROL_SECOND, 32'h02);
      window(200);
      for (int i = 6; i < 9; i++) chk(cn[i], 0);
      wr(`BCDP_OFS_SCM_CTRL, 32'h50);
      t0 = cyc;
      rd(`BCDP_OFS_SCM_STAT, 32'h0);
      while (stable !== 1'b1 && cyc - t0 < 4000) @(posedge ref_clk_i);
      near(cyc - t0, 2048, 16);
      repeat (4) @(posedge ref_clk_i);
      window(1600);
      near(cn[6], 100, 2);
      near(cn[7], 600, 14);
      near(cn[8], 300, 8);
      near(cn[0], cn[8], 1);
      rd(`BCDP_OFS_SCM_STAT, 32'h41);
      wr(`BCDP_OFS_PLL_WAIT, 32'h00);
      // The multiplier needs two divided ticks of the new source before its period is right.
      repeat (200) @(posedge ref_clk_i);
      window(2400);
      near(cn[6], 50, 2);
      near(cn[7], 300, 12);
      near(cn[8], 150, 6);
      wr(`BCDP_OFS_SCM_CTRL, 32'h00);
      repeat (8) @(posedge ref_clk_i);
      window(200);
      for (int i = 6; i < 9; i++) chk(cn[i], 0);
      rd(`BCDP_OFS_SCM_STAT, 32'h0);
      wr(`BCDP_OFS_SCM_CTRL, 32'h20);
      repeat (8) @(posedge ref_clk_i);
      window(960);
      near(cn[0], 40, 1);
      rd(`BCDP_OFS_SCM_STAT, 32'h20);
      $display("PLL test done");
      do_reset;
      zero_regs;
      $display("full reset test done");
      results;
   end
endmodule // test_bus_clock_div_pll_control
`default_nettype wire
